// *** psc_deglitch.sv ***
// module: two-flop synchroniser plus glitch filter for a pin
`timescale 1ns/1ps
module psc_deglitch #(
  parameter int CYC = 200,              // cycles a level must hold
  parameter bit RST_VAL = 1'b0          // filtered value after reset
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,            // power-on reset only
  input  wire logic pin_i,              // raw asynchronous pin
  output logic      level_o             // filtered level
);
  import psc_pkg::*;
  typedef struct packed {
    logic        s1;       // first sync stage
    logic        s2;       // second sync stage
    logic [15:0] cnt;      // stability counter
    logic        lvl;      // filtered output
  } psc_dg_t;
  psc_dg_t st, next_st;
  // count while the synced level differs from the output
  always_comb begin
    next_st    = st;
    next_st.s1 = pin_i;
    next_st.s2 = st.s1;
    if (st.s2 == st.lvl) begin
      next_st.cnt = 16'h0000;
    end else if (st.cnt >= 16'(CYC - 1)) begin
      next_st.lvl = st.s2;                            // stable long enough
      next_st.cnt = 16'h0000;
    end else begin
      next_st.cnt = st.cnt + 16'h0001;
    end
  end
  // state register
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      st <= '{s1: RST_VAL, s2: RST_VAL, cnt: 16'h0000, lvl: RST_VAL};
    end else begin
      st <= next_st;
    end
  end
  assign level_o = st.lvl;
  // a change of the output follows the synced level of the cycle before
  a_dg_hold: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    $changed(st.lvl) |-> $past(st.s2, 1) == st.lvl)
    else $error("filter output moved without stable input");
endmodule : psc_deglitch

// *** psc_pkg.sv ***
// package: constants and types for the port shutdown control block
// Functional notes
// - fast shutdown is active high, deglitched
// - qualified shutdown turns off priority-selected ports
// - eight priority levels; one- or three-bit encoding
// - reset input off all ports, registers reset
// - reset input deglitched; separate power-on reset
// - fault timer runs above cut; expiry shuts port
// - count down at 1/16; re-enable waits zero
// - semiauto: discharge port, wait 400 ms backoff
// - interrupt pin low while any status bit and its mask bit are set
// - gate low on supply low, timeout, shutdown
// - 14-bit measurements; 100 ms window average of one selected port's current
// - selectable 8- or 16-bit register access
package psc_pkg;
  // clock and timing figures
  localparam int CLK_MHZ         = 200;
  localparam int DEGLITCH_NS     = 1000;  // least pulse length accepted
  localparam int DEGLITCH_CYC    = (DEGLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int BACKOFF_MS      = 400;
  localparam int BACKOFF_CYC     = BACKOFF_MS * 1000 * CLK_MHZ;
  localparam int AVG_MS          = 100;
  localparam int AVG_CYC         = AVG_MS * 1000 * CLK_MHZ;
  localparam int NPORT           = 8;
  localparam int MEAS_W          = 14;
  localparam int FT_W            = 16;    // fault timer width
  localparam int DOWN_DIV        = 16;    // down rate divider
  // default fault limits in timer ticks (tick = one clock)
  localparam logic [FT_W-1:0] OVLD_LIM_RST  = 16'h1000;
  localparam logic [FT_W-1:0] START_LIM_RST = 16'h2000;
  // register byte offsets
  localparam logic [7:0] REG_STAT     = 8'h00; // sticky events, rc
  localparam logic [7:0] REG_MASK     = 8'h04; // interrupt mask
  localparam logic [7:0] REG_PRIO     = 8'h08; // 3 bits per port
  localparam logic [7:0] REG_CTRL     = 8'h0c; // enables / modes
  localparam logic [7:0] REG_PSTAT    = 8'h10; // port on/fault
  localparam logic [7:0] REG_CUT      = 8'h14; // cut threshold
  localparam logic [7:0] REG_LIMS     = 8'h18; // ovld/start limits
  localparam logic [7:0] REG_AVG      = 8'h1c; // avg current sel port
  localparam logic [7:0] REG_PWR_EN   = 8'h20; // write: power enable
  localparam logic [7:0] REG_PRST     = 8'h24; // write: port reset
  // reset values
  localparam logic [31:0] MASK_RST    = 32'h0000_0000;
  localparam logic [23:0] PRIO_RST    = 24'h00_0000;
  localparam logic [13:0] CUT_RST     = 14'h0400;
  // ctrl bit positions
  localparam int CTL_SEMIAUTO = 0;    // per-port semiauto mode bits 7:0
  localparam int CTL_ENC3     = 8;    // 1 = three-bit shutdown code
  localparam int CTL_ACC16    = 9;    // 1 = 16-bit access mode
  localparam int CTL_AVGSEL   = 12;   // bits 14:12 averaged port
  // status bit groups: fault[7:0], shutdown[15:8], backoff done[23:16]
  localparam int ST_FAULT = 0;
  localparam int ST_SHDN  = 8;
  localparam int ST_BOFF  = 16;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // per-port control states
  typedef enum logic [3:0] {
    PS_OFF  = 4'h1,   // off, may be enabled
    PS_BOFF = 4'h2,   // discharge backoff before detection
    PS_INR  = 4'h4,   // on, inrush limit applies
    PS_ON   = 4'h8    // on, overload limit applies
  } psc_pstate_t;
endpackage : psc_pkg

// *** psc_port_ctrl.sv ***
// module: eight-port shutdown, fault timer and interrupt logic
`timescale 1ns/1ps
module psc_port_ctrl #(
  parameter int BACKOFF_CYCLES = psc_pkg::BACKOFF_CYC, // shorten in sim
  parameter int AVG_CYCLES     = psc_pkg::AVG_CYC      // shorten in sim
) (
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_n_i,      // power-on reset
  // axi4-lite slave
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // pins
  input  wire logic [2:0]              fast_shutdown_input_i, // bit0 1-bit
  input  wire logic                    ext_reset_n_i,  // device reset pin
  input  wire logic                    supply_ok_i,    // all supplies up
  input  wire logic [psc_pkg::NPORT-1:0] over_cut_i,   // current > cut
  input  wire logic [psc_pkg::NPORT-1:0] port_hv_i,    // port > 2.5 V
  input  wire logic [psc_pkg::NPORT*psc_pkg::MEAS_W-1:0] port_current_i,
  output logic [psc_pkg::NPORT-1:0]    port_gate_drive_o,
  output logic [psc_pkg::NPORT-1:0]    discharge_en_o, // 100k switch
  output logic [psc_pkg::NPORT-1:0]    detect_start_o, // pulse
  output logic                         int_oe_o        // drives int low
);
  import psc_pkg::*;

  // whole state of the block except the pin filters
  typedef struct packed {
    logic [NPORT-1:0][3:0]      pst;     // port state codes
    logic [NPORT-1:0][FT_W-1:0] ft;      // fault timers
    logic [NPORT-1:0][3:0]      dn;      // down-count prescale
    logic [NPORT-1:0][31:0]     bo;      // backoff counters
    logic [31:0]                stat;    // sticky events
    logic [31:0]                mask;
    logic [23:0]                prio;    // 3 bits per port
    logic [15:0]                ctrl;
    logic [13:0]                cut;
    logic [FT_W-1:0]            ovld;
    logic [FT_W-1:0]            start;
    logic [31:0]                acc;     // running current sum
    logic [31:0]                win;     // window counter
    logic [MEAS_W-1:0]          avg;     // last window average
    logic                       aw_ok, w_ok;
    logic [7:0]                 awa;
    logic [31:0]                wd;
    logic [3:0]                 ws;      // captured write strobes
    logic                       bv, rv, arr;
    logic [1:0]                 br, rr;
    logic [31:0]                rd;
    logic [NPORT-1:0]           gate, dis, det;
    logic                       intr;
  } psc_st_t;
  psc_st_t st, next_st;

  logic rst_pin_n;    // deglitched reset pin
  logic [2:0] sd_lvl; // deglitched shutdown code
  logic rd_any_stat;  // access that may drop the interrupt

  // reset pin filter, idle high
  psc_deglitch #(.CYC(DEGLITCH_CYC), .RST_VAL(1'b1)) u_rst_dg (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (ext_reset_n_i),
    .level_o   (rst_pin_n)
  );
  // shutdown code filters, idle low
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sd
      psc_deglitch #(.CYC(DEGLITCH_CYC), .RST_VAL(1'b0)) u_sd (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .pin_i     (fast_shutdown_input_i[g]),
        .level_o   (sd_lvl[g])
      );
    end
  endgenerate

  // does a shutdown of code lvl hit a port with priority p
  function automatic logic sd_hits(input logic enc3, input logic [2:0] lvl,
                                   input logic [2:0] p);
    // three-bit code: ports at priority >= code go off (0 = none)
    if (enc3) sd_hits = (lvl != 3'h0) && (p >= lvl);
    else      sd_hits = lvl[0] && (p != 3'h0);
  endfunction : sd_hits

  function automatic logic hit_addr(input logic [7:0] a);
    hit_addr = (a == REG_STAT) || (a == REG_MASK) || (a == REG_PRIO) ||
               (a == REG_CTRL) || (a == REG_PSTAT) || (a == REG_CUT) ||
               (a == REG_LIMS) || (a == REG_AVG) || (a == REG_PWR_EN) ||
               (a == REG_PRST);
  endfunction : hit_addr

  // byte-lane merge; 8-bit access mode narrows writes to lane 0
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] s, input logic acc16);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i] && (acc16 || i == 0)) merge[i*8 +: 8] = d[i*8 +: 8];
    end
  endfunction : merge

  logic       sd_now;     // a qualified shutdown is present
  logic [31:0] pstat_v;   // port state view for reads
  always_comb begin
    sd_now = (st.ctrl[CTL_ENC3] ? (sd_lvl != 3'h0) : sd_lvl[0]);
    for (int i = 0; i < NPORT; i++) begin
      pstat_v[i]     = st.gate[i];
      pstat_v[i + 8] = (st.ft[i] != '0);
      pstat_v[i + 16] = st.pst[i] == PS_BOFF;
      pstat_v[i + 24] = 1'b0;
    end
  end

  // main next-state process
  always_comb begin
    logic        wr_go, rd_go;
    logic [31:0] wv;
    logic [NPORT-1:0] pen, prst;
    logic [MEAS_W-1:0] cur;
    next_st = st;
    pen = '0;
    prst = '0;
    wv = '0;
    cur = '0;
    wr_go = 1'b0;
    rd_go = 1'b0;
    // axi write channel capture, either order
    next_st.awa  = st.awa;
    if (s_axi_awvalid && !st.aw_ok) begin
      next_st.aw_ok = 1'b1;
      next_st.awa   = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.w_ok) begin
      next_st.w_ok = 1'b1;
      next_st.wd   = s_axi_wdata;
      next_st.ws   = s_axi_wstrb;
      next_st.br   = {2{1'b0}};
    end
    wr_go = st.aw_ok && st.w_ok && !st.bv;
    if (wr_go) begin
      // single write per response keeps ordering trivial
      next_st.aw_ok = 1'b0;
      next_st.w_ok  = 1'b0;
      next_st.bv    = 1'b1;
      next_st.br    = hit_addr(st.awa) ? RESP_OKAY : RESP_SLVERR;
      unique case (st.awa)
        REG_MASK: next_st.mask = merge(st.mask, st.wd, st.ws,
                                       st.ctrl[CTL_ACC16]);
        REG_PRIO: begin
          wv = merge({8'h00, st.prio}, st.wd, st.ws, st.ctrl[CTL_ACC16]);
          next_st.prio = wv[23:0];
        end
        REG_CTRL: begin
          wv = merge({16'h0000, st.ctrl}, st.wd, st.ws, 1'b1);
          next_st.ctrl = wv[15:0];
        end
        REG_CUT:    next_st.cut = st.wd[13:0];
        REG_LIMS: begin
          next_st.ovld  = st.wd[15:0];
          next_st.start = st.wd[31:16];
        end
        REG_PWR_EN: pen  = st.wd[7:0];
        REG_PRST:   prst = st.wd[7:0];
        default: ;
      endcase
    end
    if (st.bv && s_axi_bready) next_st.bv = 1'b0;
    // read channel
    rd_go = s_axi_arvalid && !st.rv && !st.arr;
    next_st.arr = rd_go;
    if (rd_go) begin
      next_st.rv = 1'b1;
      next_st.rr = hit_addr(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        REG_STAT:  next_st.rd = st.stat;
        REG_MASK:  next_st.rd = st.mask;
        REG_PRIO:  next_st.rd = {8'h00, st.prio};
        REG_CTRL:  next_st.rd = {16'h0000, st.ctrl};
        REG_PSTAT: next_st.rd = pstat_v;
        REG_CUT:   next_st.rd = {18'h00000, st.cut};
        REG_LIMS:  next_st.rd = {st.start, st.ovld};
        REG_AVG:   next_st.rd = {18'h00000, st.avg};
        default:   next_st.rd = 32'h0000_0000;
      endcase
      if (s_axi_araddr == REG_STAT) next_st.stat = 32'h0000_0000;
    end
    if (st.rv && s_axi_rready) next_st.rv = 1'b0;
    // block average of the selected port, one result per window
    cur = port_current_i[st.ctrl[CTL_AVGSEL +: 3]*MEAS_W +: MEAS_W];
    if (st.win >= 32'(AVG_CYCLES - 1)) begin
      next_st.win = 32'h0000_0000;
      next_st.avg = MEAS_W'(st.acc / 32'(AVG_CYCLES));
      next_st.acc = 32'(cur);
    end else begin
      next_st.win = st.win + 32'h0000_0001;
      next_st.acc = st.acc + 32'(cur);
    end
    // per-port logic, each port independent
    next_st.det = '0;
    for (int i = 0; i < NPORT; i++) begin
      logic off_req;
      off_req = prst[i] ||
        (sd_now && sd_hits(st.ctrl[CTL_ENC3], sd_lvl,
                           st.prio[i*3 +: 3]));
      // fault timer: up while over cut, down at 1/16 rate
      if ((st.pst[i] == PS_ON || st.pst[i] == PS_INR) && over_cut_i[i]) begin
        next_st.ft[i] = st.ft[i] + 16'h0001;
        next_st.dn[i] = 4'h0;
      end else if (st.ft[i] != '0) begin
        next_st.dn[i] = st.dn[i] + 4'h1;
        if (st.dn[i] == 4'(DOWN_DIV - 1))
          next_st.ft[i] = st.ft[i] - 16'h0001;
      end
      unique case (st.pst[i])
        PS_OFF: begin
          if (pen[i] && st.ft[i] == '0 && !off_req && supply_ok_i) begin
            if (st.ctrl[CTL_SEMIAUTO + i] && port_hv_i[i]) begin
              next_st.pst[i] = PS_BOFF;
              next_st.bo[i]  = 32'h0000_0000;
            end else begin
              next_st.pst[i] = PS_INR;
            end
          end
        end
        PS_BOFF: begin
          next_st.bo[i] = st.bo[i] + 32'h0000_0001;
          if (off_req || !supply_ok_i) begin
            next_st.pst[i] = PS_OFF;
          end else if (st.bo[i] >= 32'(BACKOFF_CYCLES - 1)) begin
            next_st.pst[i] = PS_INR;
            next_st.det[i] = 1'b1;
            next_st.stat[ST_BOFF + i] = 1'b1;
          end
        end
        PS_INR, PS_ON: begin
          if (!supply_ok_i || off_req) begin
            next_st.pst[i] = PS_OFF;
            next_st.stat[ST_SHDN + i] = 1'b1;
          end else if (over_cut_i[i] &&
              st.ft[i] >= ((st.pst[i] == PS_INR) ? st.start : st.ovld)) begin
            next_st.pst[i] = PS_OFF;
            next_st.stat[ST_FAULT + i] = 1'b1;
          end else if (st.pst[i] == PS_INR && !over_cut_i[i]) begin
            next_st.pst[i] = PS_ON;
          end
        end
        default: next_st.pst[i] = PS_OFF;
      endcase
      next_st.gate[i] = (next_st.pst[i] == PS_INR ||
                         next_st.pst[i] == PS_ON);
      next_st.dis[i]  = (next_st.pst[i] == PS_BOFF);
    end
    next_st.intr = |(next_st.stat & next_st.mask);
  end

  // state register; the reset pin acts like power-on reset
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !rst_pin_n) begin
      st       <= '0;
      st.pst   <= {NPORT{PS_OFF}};
      st.mask  <= MASK_RST;
      st.prio  <= PRIO_RST;
      st.cut   <= CUT_RST;
      st.ovld  <= OVLD_LIM_RST;
      st.start <= START_LIM_RST;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign s_axi_awready     = !st.aw_ok;
  assign s_axi_wready      = !st.w_ok;
  assign s_axi_bvalid      = st.bv;
  assign s_axi_bresp       = st.br;
  assign s_axi_arready     = st.arr;
  assign s_axi_rvalid      = st.rv;
  assign s_axi_rresp       = st.rr;
  assign s_axi_rdata       = st.rd;
  assign port_gate_drive_o = st.gate;
  assign discharge_en_o    = st.dis;
  assign detect_start_o    = st.det;
  assign int_oe_o          = st.intr;

  // checks
  // a status read clears the events, a mask write may hide them
  assign rd_any_stat = (s_axi_arvalid && !st.rv && !st.arr &&
                        s_axi_araddr == REG_STAT) ||
                       (st.aw_ok && st.w_ok && !st.bv && st.awa == REG_MASK);
  a_gate_supply: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i || !rst_pin_n)
    !supply_ok_i |=> st.gate == '0)
    else $error("gate on while supply low");
  a_int_level: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i || !rst_pin_n)
    |(st.stat & st.mask) |=> int_oe_o || $past(rd_any_stat))
    else $error("interrupt not asserted");
  // port 2 carries the fault scenario; a shutdown may win the race
  a_fault_off: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i || !rst_pin_n)
    (st.gate[2] && over_cut_i[2] &&
     st.ft[2] >= ((st.pst[2] == PS_INR) ? st.start : st.ovld))
    |=> !st.gate[2] && (st.stat[ST_FAULT + 2] || st.stat[ST_SHDN + 2]))
    else $error("overload did not shut port");
  a_reenable_zero: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i || !rst_pin_n)
    $rose(st.gate[2]) |-> $past(st.ft[2]) == '0)
    else $error("port enabled with nonzero timer");
  // off port: the timer only moves on every sixteenth cycle
  a_down_rate: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i || !rst_pin_n)
    (st.ft[2] != '0 && !st.gate[2] && st.dn[2] != 4'(DOWN_DIV - 1))
    |=> st.ft[2] == $past(st.ft[2]))
    else $error("timer fell too fast");
  a_sd_off: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i || !rst_pin_n)
    (sd_now && !st.ctrl[CTL_ENC3] && st.prio[5:3] != 3'h0)
    |=> !st.gate[1])
    else $error("shutdown left port on");
  a_boff_dis: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i || !rst_pin_n)
    st.pst[3] == PS_BOFF |-> discharge_en_o[3] && !st.gate[3])
    else $error("backoff without discharge");
  a_reset_off: assert property (@(posedge clk_sys_i)
    !rst_pin_n |=> port_gate_drive_o == '0)
    else $error("ports on during reset");
  c_fault: cover property (@(posedge clk_sys_i)
    $rose(st.stat[ST_FAULT + 2]));
  c_sd: cover property (@(posedge clk_sys_i) $fell(st.gate[0]) && sd_now);
  c_boff: cover property (@(posedge clk_sys_i) $rose(detect_start_o[3]));
endmodule : psc_port_ctrl

// *** psc_port_model.sv ***
// partner model: powered ports seen from the gate and discharge pins
`timescale 1ns/1ps
module psc_port_model (
  input  wire logic       clk_sys_i,
  input  wire logic [7:0] gate_i,     // gate drive per port
  input  wire logic [7:0] dis_i,      // discharge switch per port
  input  wire logic [7:0] short_i,    // bench orders a hard load
  input  wire logic [7:0] charged_i,  // bench leaves charge on a port
  output logic      [7:0] over_cut_o, // current above cut threshold
  output logic      [7:0] hv_o        // port above 2.5 V
);
  logic [7:0] q = 8'h00;              // residual charge per port
  // a short only draws current through a driven gate
  assign over_cut_o = gate_i & short_i;
  // charge stays until the discharge switch bleeds it off
  always_ff @(posedge clk_sys_i) begin
    q <= (q | charged_i) & ~dis_i;
  end
  // a powered port is always above the threshold
  assign hv_o = q | gate_i;
endmodule : psc_port_model

// *** test_pse_port_shutdown_control.sv ***
// testbench: registers, fast shutdown, fault timer, backoff, reset
`timescale 1ns/1ps
module test_pse_port_shutdown_control;
  import psc_pkg::*;
  logic        clk, rst_n, ext_rst_n, supply_ok;
  logic [7:0]  awaddr, araddr, gate, dis, det, ocut, hv, shrt, chg;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, int_oe;
  logic [2:0]  fsd;               // raw shutdown code pins
  logic [111:0] pcur;             // port currents, only port 0 nonzero
  int          fails = 0;
  int          samples_checked = 0;
  int          n;

  psc_port_ctrl #(.BACKOFF_CYCLES(50), .AVG_CYCLES(16)) psc_port_ctrl_i (
    .clk_sys_i(clk), .rst_n_i(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .fast_shutdown_input_i(fsd),
    .ext_reset_n_i(ext_rst_n), .supply_ok_i(supply_ok),
    .over_cut_i(ocut), .port_hv_i(hv), .port_current_i(pcur),
    .port_gate_drive_o(gate), .discharge_en_o(dis),
    .detect_start_o(det), .int_oe_o(int_oe));

  psc_port_model psc_port_model_i (
    .clk_sys_i(clk), .gate_i(gate), .dis_i(dis), .short_i(shrt),
    .charged_i(chg), .over_cut_o(ocut), .hv_o(hv));

  // one comparison, counted; unknown bits must match exactly
  task automatic check(input logic [31:0] seen, exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h want %h", $time, what,
               seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  // axi write: address and data offered together, held until taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int k;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;                    // response taken with bvalid
    bready <= 1'b0;
    if (k == 100) fails++;
    @(posedge clk);               // no reassignment at the same edge
  endtask : wr

  // axi read: result left in d and r
  task automatic rd(input logic [7:0] a);
    int k;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (k == 100) fails++;
    @(posedge clk);
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    check(d, e, "register read");
  endtask : rdc

  // bounded wait for a gate pattern, then compare
  task automatic wt(input logic [7:0] m, e);
    for (n = 0; n < 300 && (gate & m) !== e; n++) @(posedge clk);
    check(gate & m, e, "gate pattern");
  endtask : wt

  task automatic shut(input logic [2:0] c, input int len);
    fsd <= c;
    repeat (len) @(posedge clk);
    fsd <= 3'h0;
    // let the filter release so the next code starts clean
    repeat (DEGLITCH_CYC + 4) @(posedge clk);
  endtask : shut

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // watchdog: the run needs about 7k cycles
  initial begin
    #300000;
    fails++;
    give_verdict();
  end

  initial begin
    {rst_n, fsd, shrt, chg, awaddr, araddr, wdata} <= '0;
    {awvalid, wvalid, bready, arvalid, rready} <= '0;
    pcur <= 112'h123;
    ext_rst_n <= 1'b1;
    supply_ok <= 1'b1;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check({int_oe, gate}, 9'h0, "outputs after reset");
    rdc(REG_MASK, MASK_RST);
    rdc(REG_CUT, {18'h0, CUT_RST});
    rd(8'h3c);
    check(r, RESP_SLVERR, "unmapped read resp");
    check(d, 32'h0, "unmapped read data");
    wr(8'h3c, 32'h0000_0001);
    check(r, RESP_SLVERR, "unmapped write resp");
    // access width: 8-bit mode keeps lane 0 only
    wr(REG_MASK, 32'h0000_ffff);
    rdc(REG_MASK, 32'h0000_00ff);
    wr(REG_CTRL, 32'h0000_0200);
    wr(REG_MASK, 32'h0000_ffff);
    rdc(REG_MASK, 32'h0000_ffff);
    wr(REG_MASK, 32'h0);
    check(r, RESP_OKAY, "write resp");
    // one-bit shutdown: port1 priority 1, port0 priority 0
    wr(REG_PRIO, 32'h0000_0008);
    wr(REG_PWR_EN, 32'h03);
    wt(8'h03, 8'h03);
    shut(3'h1, 100);              // too short to qualify
    repeat (20) @(posedge clk);
    check(gate & 8'h03, 8'h03, "glitch ignored");
    shut(3'h1, 1100);
    wt(8'h03, 8'h01);
    check(int_oe, 1'b0, "masked event");
    wr(REG_MASK, 32'h0000_0200);
    repeat (2) @(posedge clk);
    check(int_oe, 1'b1, "unmasked event");
    rd(REG_STAT);
    check(d[ST_SHDN+1], 1'b1, "shutdown status");
    repeat (2) @(posedge clk);
    check(int_oe, 1'b0, "status cleared by read");
    // window average of port 0, several windows after reset
    rdc(REG_AVG, 32'h0000_0123);
    // inrush fault on port2 while port0 stays on
    wr(REG_LIMS, 32'h0040_0020);
    shrt <= 8'h04;
    wr(REG_PWR_EN, 32'h04);
    wt(8'h04, 8'h04);
    repeat (32) @(posedge clk);
    check(gate & 8'h05, 8'h05, "no early trip");
    wt(8'h04, 8'h00);
    check(n <= 40, 1'b1, "trip time");
    check(gate[0], 1'b1, "other port unaffected");
    shrt <= 8'h00;
    repeat (300) @(posedge clk);  // timer still counting down
    wr(REG_PWR_EN, 32'h04);
    repeat (20) @(posedge clk);
    check(gate[2], 1'b0, "re-enable refused");
    repeat (1000) @(posedge clk);
    wr(REG_PWR_EN, 32'h04);
    wt(8'h04, 8'h04);
    // three-bit codes: priorities 2, 5, 0 on ports 0..2
    wr(REG_CTRL, 32'h0000_0300);
    wr(REG_PRIO, 32'h0000_002a);
    wr(REG_PWR_EN, 32'h07);
    wt(8'h07, 8'h07);
    shut(3'h3, 1100);
    wt(8'h07, 8'h05);
    shut(3'h1, 1100);
    wt(8'h07, 8'h04);
    // semiauto backoff on a charged port3
    chg <= 8'h08;
    @(posedge clk);
    chg <= 8'h00;
    wr(REG_CTRL, 32'h0000_0308);
    wr(REG_PWR_EN, 32'h08);
    for (n = 0; n < 20 && dis[3] !== 1'b1; n++) @(posedge clk);
    check(dis[3], 1'b1, "discharge on");
    for (n = 0; n < 200 && det[3] !== 1'b1; n++) @(posedge clk);
    check(n >= 45 && n <= 55, 1'b1, "backoff length");
    // supply loss drops every gate
    supply_ok <= 1'b0;
    wt(8'hff, 8'h00);
    supply_ok <= 1'b1;
    // device reset pin
    wr(REG_CTRL, 32'h0000_0200);
    wr(REG_PWR_EN, 32'h01);
    wt(8'h01, 8'h01);
    ext_rst_n <= 1'b0;
    repeat (1100) @(posedge clk);
    check(gate, 8'h00, "gates off in reset");
    ext_rst_n <= 1'b1;
    // wait out the reset filter; only register reads follow, no detect
    repeat (DEGLITCH_CYC + 10) @(posedge clk);
    rdc(REG_MASK, MASK_RST);
    rdc(REG_PRIO, 32'h0);
    give_verdict();
  end
endmodule : test_pse_port_shutdown_control
